// ---- phy_basic_ctrl_stat.sv ----
// Overview of operation
// [RL1] Restart bit set by write, self-clears on start
// [RL2] Duplex bit picks full or half duplex
// [RL3] Autoneg enabled: negotiated duplex overrides select bit
// [RL4] Collision test: COL follows TX_EN rise quickly
// [RL5] Collision test: COL drops soon after TX_EN
// [RL6] Test off: COL from real collisions only
// [RL7] T4 ability bit always reads zero
// [RL8] Four ability bits mirror advertisement register
// [RL9] Preamble option bit mirrors sub-layer config
// [RL10] Preamble option decides preambleless frame acceptance
// [RL11] Completion bit set when negotiation completes
// [RL12] Autoneg on: remote fault from partner ability
// [RL13] Autoneg off: remote fault from far-end fault
// [RL14] Reset: abilities one, done and fault zero
// [RL15] Autoneg enable bit disables manual link selects
// [RL16] Management access works while data path isolated
// [RL17] Reserved bits read zero, writes ignored
// [RL18] Status bits read-only, writes change nothing
`timescale 1ns/1ps
module phy_basic_ctrl_stat (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_mdc,
	input wire logic i_mdio,
	input wire logic i_tx_en,
	input wire logic i_isolate,
	input wire logic i_col_detect,
	input wire logic [3:0] i_adv_ability,
	input wire logic i_mgmt_preamble_cfg,
	input wire logic i_an_started,
	input wire logic i_an_complete,
	input wire logic i_an_full_duplex,
	input wire logic i_lp_remote_fault,
	input wire logic i_far_end_fault,
	output logic o_mdio,
	output logic o_mdio_oe,
	output logic o_col,
	output logic o_autoneg_enable,
	output logic o_autoneg_restart,
	output logic o_full_duplex
);
	// Control register fields in scope
	logic an_en;
	logic restart;
	logic duplex;
	logic col_test;
	// Status register fields, sampled every cycle
	logic [3:0] abil;
	logic mgmt_preamble_optional;
	logic an_done;
	logic rfault;
	// Bus side
	logic [4:0] reg_addr;
	logic wr_strobe;
	logic [15:0] wr_data;
	logic [15:0] rd_data;
	logic wr_ctl;
	// Transmit enable synchroniser, from the MAC clock domain
	logic tx_en_s1, tx_en_s2;

	mgmt_serial_slave u_slave ( // [RL16]
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_mdc(i_mdc),
		.i_mdio(i_mdio),
		.i_preamble_optional(mgmt_preamble_optional),
		.i_rd_data(rd_data),
		.o_reg_addr(reg_addr),
		.o_wr_strobe(wr_strobe),
		.o_wr_data(wr_data),
		.o_mdio(o_mdio),
		.o_mdio_oe(o_mdio_oe)
	);

	// Writes to the status register or any other number are dropped
	assign wr_ctl = wr_strobe && reg_addr == phy_mgmt_pkg::REG_CONTROL; // [RL18]

	// Read mux; reserved and out-of-scope bits read as zero
	always_comb begin
		rd_data = 16'h0000; // [RL17]
		if (reg_addr == phy_mgmt_pkg::REG_CONTROL) begin
			rd_data[phy_mgmt_pkg::CTL_AN_EN] = an_en;
			rd_data[phy_mgmt_pkg::CTL_RESTART] = restart;
			rd_data[phy_mgmt_pkg::CTL_DUPLEX] = duplex;
			rd_data[phy_mgmt_pkg::CTL_COL_TEST] = col_test;
		end else if (reg_addr == phy_mgmt_pkg::REG_STATUS) begin
			rd_data[phy_mgmt_pkg::STA_T4] = 1'h0; // [RL7]
			rd_data[phy_mgmt_pkg::STA_ABIL_HI:phy_mgmt_pkg::STA_ABIL_LO] = abil;
			rd_data[phy_mgmt_pkg::STA_PRE_OPT] = mgmt_preamble_optional;
			rd_data[phy_mgmt_pkg::STA_AN_DONE] = an_done;
			rd_data[phy_mgmt_pkg::STA_RFAULT] = rfault;
		end
	end

	// Plain read/write control fields
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			an_en <= phy_mgmt_pkg::RST_AN_EN;
			duplex <= phy_mgmt_pkg::RST_DUPLEX;
			col_test <= phy_mgmt_pkg::RST_COL_TEST;
		end else if (wr_ctl) begin
			an_en <= wr_data[phy_mgmt_pkg::CTL_AN_EN]; // [RL15]
			duplex <= wr_data[phy_mgmt_pkg::CTL_DUPLEX];
			col_test <= wr_data[phy_mgmt_pkg::CTL_COL_TEST];
		end
	end

	// Act-once restart; a written one wins over a same-cycle start
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			restart <= phy_mgmt_pkg::RST_RESTART;
		end else if (wr_ctl && wr_data[phy_mgmt_pkg::CTL_RESTART]) begin
			restart <= 1'h1; // [RL1]
		end else if (i_an_started) begin
			restart <= 1'h0; // [RL1]
		end
	end

	// Status snapshot; hardware inputs feed these flops, with an_en choosing the fault source
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			abil <= phy_mgmt_pkg::RST_ABIL; // [RL14]
			mgmt_preamble_optional <= phy_mgmt_pkg::RST_PRE_OPT;
			an_done <= phy_mgmt_pkg::RST_AN_DONE;
			rfault <= phy_mgmt_pkg::RST_RFAULT;
		end else begin
			abil <= i_adv_ability; // [RL8]
			mgmt_preamble_optional <= i_mgmt_preamble_cfg; // [RL9]
			an_done <= i_an_complete; // [RL11]
			// Fault source depends on whether negotiation is enabled
			rfault <= an_en ? i_lp_remote_fault : i_far_end_fault; // [RL12] [RL13]
		end
	end

	// Two flops on transmit enable; costs two of the ten allowed cycles
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tx_en_s1 <= 1'h0;
			tx_en_s2 <= 1'h0;
		end else begin
			tx_en_s1 <= i_tx_en;
			tx_en_s2 <= tx_en_s1;
		end
	end

	// Collision output; held low while the data path is isolated
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_col <= 1'h0;
		end else if (i_isolate) begin
			o_col <= 1'h0;
		end else if (col_test) begin
			o_col <= tx_en_s2; // [RL4] [RL5]
		end else begin
			o_col <= i_col_detect; // [RL6]
		end
	end

	// Link configuration outputs
	assign o_autoneg_enable = an_en;
	assign o_autoneg_restart = restart;
	assign o_full_duplex = an_en ? i_an_full_duplex : duplex; // [RL2] [RL3]

	// Control register behaviour
	chk_restart_self_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
		(restart && i_an_started && !wr_ctl) |=> !restart)
		else $error("restart bit did not clear after negotiation began");
	chk_restart_zero_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
		(restart && !i_an_started && wr_ctl) |=> restart)
		else $error("writing the control register dropped a pending restart");
	chk_duplex_manual: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL2]
		!an_en |-> (o_full_duplex == duplex))
		else $error("duplex does not follow the select bit");
	chk_duplex_negotiated: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL3]
		an_en |-> (o_full_duplex == i_an_full_duplex))
		else $error("duplex select bit leaked through while negotiating");

	// Collision output; test-mode checks watch only the settled second sync stage
	chk_col_test_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL4]
		($rose(tx_en_s2) && col_test && !i_isolate) |=> o_col)
		else $error("collision test did not raise the collision output in time");
	chk_col_test_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL5]
		(!tx_en_s2 && col_test) |=> !o_col)
		else $error("collision test did not drop the collision output in time");
	chk_col_normal: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL6]
		(!col_test && !i_isolate) |=> (o_col == $past(i_col_detect)))
		else $error("collision output not driven from real collisions");

	// Status register contents
	chk_status_fixed: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL7]
		(reg_addr == phy_mgmt_pkg::REG_STATUS) |-> (rd_data[15] == 1'h0
		&& rd_data[10:7] == 4'h0 && rd_data[3:0] == 4'h0))
		else $error("status reserved or unsupported bits read nonzero");
	chk_status_mirror: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL8]
		$past(i_rst_n) |-> (abil == $past(i_adv_ability)
		&& mgmt_preamble_optional == $past(i_mgmt_preamble_cfg)))
		else $error("ability or preamble status does not mirror its source");
	chk_fault_source: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL12]
		$past(i_rst_n) |-> (rfault == ($past(an_en) ? $past(i_lp_remote_fault)
		: $past(i_far_end_fault))))
		else $error("remote fault status from the wrong source");
	chk_reset_values: assert property (@(posedge i_clk) // [RL14]
		!i_rst_n |=> (abil == 4'hf && mgmt_preamble_optional && !an_done && !rfault))
		else $error("status reset values wrong");

	// Register bus side, completion status and isolation
	chk_restart_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL1]
		(wr_ctl && wr_data[phy_mgmt_pkg::CTL_RESTART]) |=> restart)
		else $error("written restart bit did not set");
	chk_ctl_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL18]
		!wr_ctl |=> ($stable(an_en) && $stable(duplex) && $stable(col_test)))
		else $error("control fields changed without a control write");
	chk_ctl_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL17]
		(reg_addr == phy_mgmt_pkg::REG_CONTROL) |-> (rd_data[15:13] == 3'h0
		&& rd_data[11:10] == 2'h0 && rd_data[6:0] == 7'h00))
		else $error("control reserved bits read nonzero");
	chk_an_done_mirror: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL11]
		$past(i_rst_n) |-> (an_done == $past(i_an_complete)))
		else $error("completion status does not follow negotiation");
	chk_isolate_col: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL16]
		i_isolate |=> !o_col)
		else $error("collision output active while isolated");
endmodule // phy_basic_ctrl_stat

// ---- phy_mgmt_pkg.sv ----
package phy_mgmt_pkg;
	// Register numbers on the serial management bus
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h01;
	// This device's bus address
	localparam logic [4:0] PHY_ADDR = 5'h01;
	// Frame opcodes
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// Preamble length in bits; last bit counts for header and data
	localparam logic [5:0] PREAMBLE_BITS = 6'h20;
	localparam logic [3:0] HDR_LAST = 4'hc;
	localparam logic [3:0] DATA_LAST = 4'hf;
	// Control field positions
	localparam int CTL_AN_EN = 12;
	localparam int CTL_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_COL_TEST = 7;
	// Status field positions
	localparam int STA_T4 = 15;
	localparam int STA_ABIL_HI = 14;
	localparam int STA_ABIL_LO = 11;
	localparam int STA_PRE_OPT = 6;
	localparam int STA_AN_DONE = 5;
	localparam int STA_RFAULT = 4;
	// Reset values
	localparam logic RST_AN_EN = 1'h1;
	localparam logic RST_DUPLEX = 1'h0;
	localparam logic RST_COL_TEST = 1'h0;
	localparam logic RST_RESTART = 1'h0;
	localparam logic [3:0] RST_ABIL = 4'hf;
	localparam logic RST_PRE_OPT = 1'h1;
	localparam logic RST_AN_DONE = 1'h0;
	localparam logic RST_RFAULT = 1'h0;
	// Collision test timing, bit times at 100 Mb/s are 10 ns
	localparam int CLK_NS = 10;
	localparam int BIT_NS = 10;
	localparam int COL_ON_BITS = 10;
	localparam int COL_OFF_BITS = 4;
	localparam int COL_ON_CYC = (COL_ON_BITS * BIT_NS) / CLK_NS;
	localparam int COL_OFF_CYC = (COL_OFF_BITS * BIT_NS) / CLK_NS;
endpackage

// ---- mgmt_serial_slave.sv ----
`timescale 1ns/1ps
module mgmt_serial_slave (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_mdc,
	input wire logic i_mdio,
	input wire logic i_preamble_optional,
	input wire logic [15:0] i_rd_data,
	output logic [4:0] o_reg_addr,
	output logic o_wr_strobe,
	output logic [15:0] o_wr_data,
	output logic o_mdio,
	output logic o_mdio_oe
);
	// Frame phases
	typedef enum logic [5:0] {
		S_PRE = 6'h01,
		S_HDR = 6'h02,
		S_TA1 = 6'h04,
		S_TA2 = 6'h08,
		S_RDATA = 6'h10,
		S_WDATA = 6'h20
	} frame_state_t;

	frame_state_t state;
	logic mdc_s1, mdc_s2, mdc_d; // Clock pin synchroniser and edge history
	logic mdio_s1, mdio_s2; // Data pin synchroniser
	logic rise; // Sampling edge of the management clock
	logic [5:0] ones; // Run of idle ones, saturates at preamble length
	logic [3:0] cnt; // Bit counter within header or data
	logic [12:0] hdr; // Header bits after the start zero
	logic [12:0] next_hdr;
	logic [15:0] sh; // Data shifter, both directions
	logic is_read;
	logic hdr_ok;

	// Both pins pass two flops; the edge test compares the second clock stage with its delayed copy
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			// Clock stages start high, where the clock rests between frames,
			// so a released reset never fakes a sampling edge
			mdc_s1 <= 1'h1;
			mdc_s2 <= 1'h1;
			mdc_d <= 1'h1;
			mdio_s1 <= 1'h1;
			mdio_s2 <= 1'h1;
		end else begin
			mdc_s1 <= i_mdc;
			mdc_s2 <= mdc_s1;
			mdc_d <= mdc_s2;
			mdio_s1 <= i_mdio;
			mdio_s2 <= mdio_s1;
		end
	end

	assign rise = mdc_s2 & ~mdc_d;
	assign next_hdr = {hdr[11:0], mdio_s2};
	// Start bit, our address and a known opcode
	assign hdr_ok = next_hdr[12] && (next_hdr[9:5] == phy_mgmt_pkg::PHY_ADDR)
		&& (next_hdr[11:10] == phy_mgmt_pkg::OP_READ
		|| next_hdr[11:10] == phy_mgmt_pkg::OP_WRITE);

	// Frame walker; runs regardless of data path isolation
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state <= S_PRE;
			ones <= 6'h00;
			cnt <= 4'h0;
			hdr <= 13'h0000;
			sh <= 16'h0000;
			is_read <= 1'h0;
			o_reg_addr <= 5'h00;
			o_wr_strobe <= 1'h0;
			o_wr_data <= 16'h0000;
			o_mdio <= 1'h1;
			o_mdio_oe <= 1'h0;
		end else begin
			o_wr_strobe <= 1'h0;
			if (rise) begin
				case (state)
					S_PRE: begin
						if (mdio_s2) begin
							if (ones != phy_mgmt_pkg::PREAMBLE_BITS)
								ones <= ones + 6'h01;
						// Preamble may be skipped only when the option is on
						end else if (ones == phy_mgmt_pkg::PREAMBLE_BITS
							|| (i_preamble_optional && ones != 6'h00)) begin // [RL10]
							state <= S_HDR;
							cnt <= 4'h0;
						end else begin
							ones <= 6'h00;
						end
					end
					S_HDR: begin
						hdr <= next_hdr;
						cnt <= cnt + 4'h1;
						if (cnt == phy_mgmt_pkg::HDR_LAST) begin
							ones <= 6'h00;
							// Foreign or malformed frames are dropped silently
							state <= hdr_ok ? S_TA1 : S_PRE;
							is_read <= next_hdr[11:10] == phy_mgmt_pkg::OP_READ;
							o_reg_addr <= next_hdr[4:0];
						end
					end
					S_TA1: begin
						state <= S_TA2;
						// Drive the turnaround zero on a read
						o_mdio <= 1'h0;
						o_mdio_oe <= is_read;
					end
					S_TA2: begin
						cnt <= 4'h0;
						if (is_read) begin
							state <= S_RDATA;
							o_mdio <= i_rd_data[15];
							sh <= {i_rd_data[14:0], 1'h0};
						end else begin
							state <= S_WDATA;
						end
					end
					S_RDATA: begin
						cnt <= cnt + 4'h1;
						if (cnt == phy_mgmt_pkg::DATA_LAST) begin
							state <= S_PRE;
							o_mdio <= 1'h1;
							o_mdio_oe <= 1'h0;
						end else begin
							o_mdio <= sh[15];
							sh <= {sh[14:0], 1'h0};
						end
					end
					S_WDATA: begin
						cnt <= cnt + 4'h1;
						sh <= {sh[14:0], mdio_s2};
						if (cnt == phy_mgmt_pkg::DATA_LAST) begin
							state <= S_PRE;
							o_wr_data <= {sh[14:0], mdio_s2};
							o_wr_strobe <= 1'h1;
						end
					end
					default: state <= S_PRE;
				endcase
			end
		end
	end

	// Bus is only driven during the read part of a frame
	chk_release_after_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RL16]
		(state == S_WDATA) |-> !o_mdio_oe)
		else $error("management pin driven during write data");
endmodule // mgmt_serial_slave

// ---- mgmt_station.sv ----
`timescale 1ns/1ps
module mgmt_station (
	input wire logic i_clk,
	input wire logic i_dut_mdio,
	input wire logic i_dut_oe,
	output logic o_mdc,
	output logic o_line
);
	logic drive; // Station owns the line
	logic val; // Station's bit
	// Pulled-up shared line; device wins while its enable is high
	assign o_line = i_dut_oe ? i_dut_mdio : (drive ? val : 1'b1);
	initial begin
		o_mdc = 1'b0;
		drive = 1'b0;
		val = 1'b1;
	end
	// One bit: 5 clocks low, sample, 5 clocks high; MDC rests high after
	task automatic clk_bit(input logic b, input logic own, output logic seen);
		drive = own;
		val = b;
		o_mdc = 1'b0;
		repeat (5) @(negedge i_clk);
		seen = o_line;
		o_mdc = 1'b1;
		repeat (5) @(negedge i_clk);
	endtask
	// Whole frame, MSB first; reads release the line from turnaround on
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, input logic pre, output logic [15:0] rd);
		logic [13:0] hdr;
		logic s;
		hdr = {2'b01, op, phy, rg};
		rd = 16'h0000;
		// One idle one stands in when the preamble is left out
		repeat (pre ? 32 : 1) clk_bit(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
		clk_bit(1'b1, op == 2'h1, s);
		clk_bit(1'b0, op == 2'h1, s);
		for (int i = 15; i >= 0; i--) begin
			clk_bit(wd[i], op == 2'h1, s);
			rd[i] = s;
		end
		drive = 1'b0;
	endtask
endmodule // mgmt_station

// ---- phy_basic_ctrl_stat_test.sv ----
`timescale 1ns/1ps
module phy_basic_ctrl_stat_test;
	logic clk = 1'b0; // 100 MHz
	logic rst_n = 1'b0;
	logic mdc, line, tx_en, iso, col_det, pre_cfg, an_go, an_done, an_fd, lp_f, fe_f;
	logic [3:0] abil;
	logic o_mdio, o_oe, o_col, an_en, an_rs, fdx;
	int mismatches = 0;
	int n_tests = 0;
	logic [15:0] d; // Last read word
	always #5 clk = ~clk;
	phy_basic_ctrl_stat dut (.i_clk(clk), .i_rst_n(rst_n), .i_mdc(mdc), .i_mdio(line),
		.i_tx_en(tx_en), .i_isolate(iso), .i_col_detect(col_det), .i_adv_ability(abil),
		.i_mgmt_preamble_cfg(pre_cfg), .i_an_started(an_go), .i_an_complete(an_done),
		.i_an_full_duplex(an_fd), .i_lp_remote_fault(lp_f), .i_far_end_fault(fe_f),
		.o_mdio(o_mdio), .o_mdio_oe(o_oe), .o_col(o_col), .o_autoneg_enable(an_en),
		.o_autoneg_restart(an_rs), .o_full_duplex(fdx));
	mgmt_station sta (.i_clk(clk), .i_dut_mdio(o_mdio), .i_dut_oe(o_oe), .o_mdc(mdc),
		.o_line(line));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic rreg(input logic [4:0] a, input logic [4:0] rg, input logic pre);
		sta.frame(phy_mgmt_pkg::OP_READ, a, rg, 16'h0000, pre, d);
	endtask
	// Write, then let the register update land
	task automatic wreg(input logic [4:0] rg, input logic [15:0] wd);
		logic [15:0] x;
		sta.frame(phy_mgmt_pkg::OP_WRITE, phy_mgmt_pkg::PHY_ADDR, rg, wd, 1'b1, x);
		repeat (6) @(negedge clk);
	endtask
	// Bounded wait on the collision pin
	task automatic wait_col(input logic v, input int lim);
		int n;
		n = 0;
		while (o_col !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("col", 16'(o_col), 16'(v));
	endtask
	task automatic t_reset();
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("status rst", d, 16'h7840);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_CONTROL, 1'b1);
		chk("control rst", d, 16'h1000);
	endtask
	task automatic t_status();
		abil = 4'ha;
		an_done = 1'b1;
		lp_f = 1'b1;
		wreg(phy_mgmt_pkg::REG_STATUS, 16'h0000);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("status", d, 16'h5070);
		pre_cfg = 1'b0;
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("pre bit", d, 16'h5030);
		pre_cfg = 1'b1;
		abil = 4'hf;
		an_done = 1'b0;
	endtask
	task automatic t_ctrl();
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'hff7f);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_CONTROL, 1'b1);
		chk("control", d, 16'h1300);
		chk("restart", 16'(an_rs), 16'h0001);
		chk("an duplex", 16'(fdx), 16'h0000);
		// Negotiated result, not the select bit, must reach the output
		an_fd = 1'b1;
		@(negedge clk);
		chk("an result", 16'(fdx), 16'h0001);
		an_fd = 1'b0;
		// A zero written to the restart bit leaves a pending restart alone
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'h1000);
		chk("restart kept", 16'(an_rs), 16'h0001);
		an_go = 1'b1;
		@(negedge clk);
		an_go = 1'b0;
		repeat (3) @(negedge clk);
		chk("restart clr", 16'(an_rs), 16'h0000);
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'h0100);
		chk("an off", 16'(an_en), 16'h0000);
		chk("full", 16'(fdx), 16'h0001);
		chk("restart 0", 16'(an_rs), 16'h0000);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("lp fault off", d & 16'h0010, 16'h0000);
		fe_f = 1'b1;
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("far fault", d & 16'h0010, 16'h0010);
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'h0000);
		chk("half", 16'(fdx), 16'h0000);
		fe_f = 1'b0;
		lp_f = 1'b0;
	endtask
	task automatic t_col();
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'h1080);
		tx_en = 1'b1;
		wait_col(1'b1, phy_mgmt_pkg::COL_ON_CYC);
		tx_en = 1'b0;
		wait_col(1'b0, phy_mgmt_pkg::COL_OFF_CYC);
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'h1000);
		tx_en = 1'b1;
		repeat (12) @(negedge clk);
		chk("no test col", 16'(o_col), 16'h0000);
		col_det = 1'b1;
		wait_col(1'b1, 3);
		iso = 1'b1;
		wait_col(1'b0, 3);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("isolated read", d, 16'h7840);
		iso = 1'b0;
		col_det = 1'b0;
		tx_en = 1'b0;
	endtask
	task automatic t_pre();
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b0);
		chk("short ok", d, 16'h7840);
		pre_cfg = 1'b0;
		repeat (3) @(negedge clk);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b0);
		chk("short ignored", d, 16'hffff);
		rreg(5'h02, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("other phy", d, 16'hffff);
		// Unknown opcode: frame dropped, line stays at its pull-up
		sta.frame(2'h3, phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 16'h0000, 1'b1, d);
		chk("bad op", d, 16'hffff);
		rreg(phy_mgmt_pkg::PHY_ADDR, 5'h02, 1'b1);
		chk("unmapped", d, 16'h0000);
		rreg(phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::REG_STATUS, 1'b1);
		chk("pre needed", d, 16'h7800);
		pre_cfg = 1'b1;
	endtask
	initial begin
		{tx_en, iso, col_det, an_go, an_done, an_fd, lp_f, fe_f} = 8'h00;
		pre_cfg = 1'b1;
		abil = 4'hf;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_status();
		t_ctrl();
		t_col();
		t_pre();
		close_out();
	end
endmodule // phy_basic_ctrl_stat_test
